// ### common/dfr_link_if.sv
/*
  Command link between the flash read front end and its host.
  Assumes a pull-up on the serial output and on the byte bus when nobody drives.
*/
interface dfr_link_if;
  logic       csN;
  logic       sck;
  logic       si;
  logic       so;
  logic       soOe;
  logic       soLine;
  logic       linkWidthSelect;
  logic [7:0] hostByteOut;
  logic       hostByteOe;
  logic [7:0] devByteOut;
  logic       devByteOe;
  logic [7:0] byteBus;

  // Wire resolution; device wins if both ever drive
  assign byteBus = devByteOe ? devByteOut : (hostByteOe ? hostByteOut : 8'hFF);
  assign soLine  = soOe ? so : 1'b1;

  modport dev  (input csN, sck, si, linkWidthSelect, byteBus,
                output so, soOe, devByteOut, devByteOe);
  modport host (output csN, sck, si, linkWidthSelect, hostByteOut, hostByteOe,
                input soLine, byteBus);
endinterface

// ### common/dfr_pkg.sv
/*
  Shared constants, types and decode helpers for the dual-link flash read front end.
  Assumes both ends import this package whole and agree on link timing counts.
*/
// Notes on behaviour
// - Chip select low starts opcode then address.
// - Everything shifts most significant bit first.
// - Buffer byte chosen by 11-bit address.
// - Array address is page then byte offset.
// - 16384 pages of 1056 bytes each.
// - Array address: 7 blanks then 25 bits.
// - Continuous read E8; dummy 24 or 19.
// - Address counter advances by itself.
// - Page end runs into next page.
// - Array end wraps to page zero.
// - Chip select high ends read, floats outputs.
// - Array reads never touch buffers.
// - Page read D2, same format.
// - Page read wraps within its page.
// - Serial buffer reads D4 and D6.
// - Byte-link buffer reads 54 and 56.
// - Buffer address: 21 blanks, 11 bits.
// - Buffer dummy: one or two bytes.
// - Buffer read wraps to buffer start.
// - Host holds select low whole command.
// - Works in clock modes 0 and 3.
// - After dummies each clock gives data.
package dfr_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int          PAGE_W     = 14;
  localparam int          OFF_W      = 11;
  localparam int          ADDR_W     = PAGE_W + OFF_W;
  localparam int          ADR_BITS   = 32;
  localparam int          PAGE_BYTES = 1056;
  localparam int          PAGE_COUNT = 16384;
  localparam logic [10:0] LAST_OFF   = 11'h41F;
  localparam logic [13:0] PAGE_ONE   = 14'h0001;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_CONT  = 8'hE8;
  localparam logic [7:0] OPC_PAGE  = 8'hD2;
  localparam logic [7:0] OPC_SBUF1 = 8'hD4;
  localparam logic [7:0] OPC_SBUF2 = 8'hD6;
  localparam logic [7:0] OPC_BBUF1 = 8'h54;
  localparam logic [7:0] OPC_BBUF2 = 8'h56;

  // ---------------------------------------------------------------
  // Link clock counts per phase
  // ---------------------------------------------------------------
  localparam logic [5:0] SER_OPC_CLKS   = 6'h08;
  localparam logic [5:0] BYTE_OPC_CLKS  = 6'h01;
  localparam logic [5:0] SER_ADR_CLKS   = 6'h20;
  localparam logic [5:0] BYTE_ADR_CLKS  = 6'h04;
  localparam logic [5:0] SER_ARR_DUMMY  = 6'h18;
  localparam logic [5:0] BYTE_ARR_DUMMY = 6'h13;
  localparam logic [5:0] SER_BUF_DUMMY  = 6'h08;
  localparam logic [5:0] BYTE_BUF_DUMMY = 6'h02;
  localparam logic [5:0] ONE_CLK        = 6'h01;

  // Reference cycles per half link clock on the host
  localparam logic [2:0] HALF_DIV = 3'h4;

  typedef enum logic [2:0] {K_NONE, K_CONT, K_PAGE, K_BUF1, K_BUF2} dfr_kind_t;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic dfr_kind_t decodeKind(input logic [7:0] opc, input logic byteMode);
    dfr_kind_t k;
    k = K_NONE;
    if (opc == OPC_CONT) k = K_CONT;
    else if (opc == OPC_PAGE) k = K_PAGE;
    else if (!byteMode && opc == OPC_SBUF1) k = K_BUF1;
    else if (!byteMode && opc == OPC_SBUF2) k = K_BUF2;
    else if (byteMode && opc == OPC_BBUF1) k = K_BUF1;
    else if (byteMode && opc == OPC_BBUF2) k = K_BUF2;
    return k;
  endfunction

  function automatic logic [5:0] dummyClks(input dfr_kind_t k, input logic byteMode);
    logic [5:0] n;
    n = 6'h00;
    if (k == K_CONT || k == K_PAGE) n = byteMode ? BYTE_ARR_DUMMY : SER_ARR_DUMMY;
    else if (k == K_BUF1 || k == K_BUF2) n = byteMode ? BYTE_BUF_DUMMY : SER_BUF_DUMMY;
    return n;
  endfunction

  function automatic logic isBufKind(input dfr_kind_t k);
    return (k == K_BUF1) || (k == K_BUF2);
  endfunction

endpackage

// ### hdl/dfr_dev.sv
/*
  Device end of the flash read front end: command decode, address counter,
  array fetch port, two on-chip buffers and the serial or byte-wide read path.
  Assumes the array answers arrayAddr combinationally within one link clock, and
  that the buffer fill port is idle while a buffer read frame runs.
*/
module dfr_dev
  import dfr_pkg::*;
(
  // Link
  dfr_link_if.dev                 link,
  // Reset, synchronous to the link clock
  input  wire logic               rst,
  // Main array fetch port, link clock
  output logic [ADDR_W-1:0]       arrayAddr,
  input  wire logic [7:0]         arrayData,
  // Buffer fill port
  input  wire logic               usrClk,
  input  wire logic               bufWrEn,
  input  wire logic               bufWrSel,
  input  wire logic [OFF_W-1:0]   bufWrAddr,
  input  wire logic [7:0]         bufWrData
);

  typedef enum logic [2:0] {S_OPC, S_ADR, S_DUM, S_DAT, S_IGN} dfr_dstate_t;

  // ---------------------------------------------------------------
  // Buffers
  // ---------------------------------------------------------------
  // Only the fill port writes; reads below never do
  logic [7:0] bufMem [2][PAGE_BYTES];

  always_ff @(posedge usrClk) begin
    if (bufWrEn && bufWrAddr <= LAST_OFF) begin
      bufMem[bufWrSel][bufWrAddr] <= bufWrData;
    end
  end

  // ---------------------------------------------------------------
  // Rising-edge state
  // ---------------------------------------------------------------
  dfr_dstate_t        st_r,      st_nxt;
  logic [5:0]         cnt_r,     cnt_nxt;
  logic [7:0]         opc_r,     opc_nxt;
  logic [ADR_BITS-1:0] adr_r,    adr_nxt;
  dfr_kind_t          kind_r,    kind_nxt;
  logic [PAGE_W-1:0]  page_r,    page_nxt;
  logic [OFF_W-1:0]   off_r,     off_nxt;
  logic [7:0]         outByte_r, outByte_nxt;
  logic [2:0]         bitIdx_r,  bitIdx_nxt;
  logic               dataOn_r,  dataOn_nxt;

  logic               byteMode;
  logic [7:0]         opcIn;
  logic [ADR_BITS-1:0] adrIn;
  logic [7:0]         fetchByte;
  logic               load;
  logic [5:0]         opcLast;
  logic [5:0]         adrLast;

  assign byteMode = link.linkWidthSelect;

  // Next location; only the continuous read leaves the page
  function automatic logic [ADDR_W-1:0] nextPos(input dfr_kind_t k, input logic [PAGE_W-1:0] pg,
                                                input logic [OFF_W-1:0] of);
    logic [PAGE_W-1:0] p;
    logic [OFF_W-1:0]  o;
    p = pg;
    o = of + 11'h001;
    if (of >= LAST_OFF) begin
      o = 11'h000;
      if (k == K_CONT) p = pg + PAGE_ONE;
    end
    return {p, o};
  endfunction

  always_comb begin
    fetchByte = arrayData;
    if (isBufKind(kind_r)) begin
      // Offsets past the last byte read as zero
      fetchByte = (off_r <= LAST_OFF) ? bufMem[kind_r == K_BUF2][off_r] : 8'h00;
    end
  end

  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r + ONE_CLK;
    opc_nxt     = opc_r;
    adr_nxt     = adr_r;
    kind_nxt    = kind_r;
    page_nxt    = page_r;
    off_nxt     = off_r;
    outByte_nxt = outByte_r;
    bitIdx_nxt  = bitIdx_r;
    dataOn_nxt  = dataOn_r;
    load        = 1'b0;
    opcLast     = (byteMode ? BYTE_OPC_CLKS : SER_OPC_CLKS) - ONE_CLK;
    adrLast     = (byteMode ? BYTE_ADR_CLKS : SER_ADR_CLKS) - ONE_CLK;
    opcIn       = byteMode ? link.byteBus : {opc_r[6:0], link.si};
    adrIn       = byteMode ? {adr_r[23:0], link.byteBus} : {adr_r[30:0], link.si};
    unique case (st_r)
      S_OPC: begin
        opc_nxt = opcIn;
        if (cnt_r == opcLast) begin
          kind_nxt = decodeKind(opcIn, byteMode);
          st_nxt   = (decodeKind(opcIn, byteMode) == K_NONE) ? S_IGN : S_ADR;
          cnt_nxt  = 6'h00;
        end
      end
      S_ADR: begin
        adr_nxt = adrIn;
        if (cnt_r == adrLast) begin
          page_nxt = adrIn[ADDR_W-1:OFF_W];
          off_nxt  = adrIn[OFF_W-1:0];
          st_nxt   = S_DUM;
          cnt_nxt  = 6'h00;
        end
      end
      S_DUM: begin
        if (cnt_r == dummyClks(kind_r, byteMode) - ONE_CLK) begin
          load       = 1'b1;
          dataOn_nxt = 1'b1;
          st_nxt     = S_DAT;
          cnt_nxt    = 6'h00;
        end
      end
      S_DAT: begin
        cnt_nxt = cnt_r;
        if (byteMode || bitIdx_r == 3'h0) begin
          load = 1'b1;
        end else begin
          bitIdx_nxt = bitIdx_r - 3'h1;
        end
      end
      S_IGN: begin
        // Unknown opcode: sit out the rest of the frame
        cnt_nxt = cnt_r;
      end
    endcase
    if (load) begin
      outByte_nxt         = fetchByte;
      bitIdx_nxt          = 3'h7;
      {page_nxt, off_nxt} = nextPos(kind_r, page_r, off_r);
    end
    if (rst) begin
      st_nxt      = S_OPC;
      cnt_nxt     = 6'h00;
      opc_nxt     = 8'h00;
      adr_nxt     = '0;
      kind_nxt    = K_NONE;
      page_nxt    = '0;
      off_nxt     = '0;
      outByte_nxt = 8'h00;
      bitIdx_nxt  = 3'h7;
      dataOn_nxt  = 1'b0;
    end
  end

  // Select high clears the frame at once, since the clock may stop with it
  always_ff @(posedge link.sck or posedge link.csN) begin
    if (link.csN) begin
      st_r      <= S_OPC;
      cnt_r     <= 6'h00;
      opc_r     <= 8'h00;
      adr_r     <= '0;
      kind_r    <= K_NONE;
      page_r    <= '0;
      off_r     <= '0;
      outByte_r <= 8'h00;
      bitIdx_r  <= 3'h7;
      dataOn_r  <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      opc_r     <= opc_nxt;
      adr_r     <= adr_nxt;
      kind_r    <= kind_nxt;
      page_r    <= page_nxt;
      off_r     <= off_nxt;
      outByte_r <= outByte_nxt;
      bitIdx_r  <= bitIdx_nxt;
      dataOn_r  <= dataOn_nxt;
    end
  end

  // Address counter flops feed the array directly
  assign arrayAddr = {page_r, off_r};

  // ---------------------------------------------------------------
  // Falling-edge output stage
  // ---------------------------------------------------------------
  // Launching on the falling edge gives the host a half period of setup
  logic       so_r,     so_nxt;
  logic       soOe_r,   soOe_nxt;
  logic [7:0] bOut_r,   bOut_nxt;
  logic       bOe_r,    bOe_nxt;

  always_comb begin
    so_nxt   = outByte_r[bitIdx_r];
    soOe_nxt = dataOn_r && !byteMode;
    bOut_nxt = outByte_r;
    bOe_nxt  = dataOn_r && byteMode;
    if (rst) begin
      so_nxt   = 1'b0;
      soOe_nxt = 1'b0;
      bOut_nxt = 8'h00;
      bOe_nxt  = 1'b0;
    end
  end

  always_ff @(negedge link.sck or posedge link.csN) begin
    if (link.csN) begin
      so_r   <= 1'b0;
      soOe_r <= 1'b0;
      bOut_r <= 8'h00;
      bOe_r  <= 1'b0;
    end else begin
      so_r   <= so_nxt;
      soOe_r <= soOe_nxt;
      bOut_r <= bOut_nxt;
      bOe_r  <= bOe_nxt;
    end
  end

  assign link.so         = so_r;
  assign link.soOe       = soOe_r;
  assign link.devByteOut = bOut_r;
  assign link.devByteOe  = bOe_r;

endmodule

// ### hdl/dfr_host.sv
/*
  Host end of the flash read link: frames one read command, makes the link
  clock by dividing ref_clk, and returns read bytes as one-cycle strobes.
  Assumes the device launches data on the falling link edge.
*/
module dfr_host
  import dfr_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Command request
  input  wire logic              cmdStart,
  input  wire logic [7:0]        cmdOpcode,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic              cmdByteMode,
  input  wire logic [11:0]       cmdLen,
  // Command answer
  output logic                   cmdBusy,
  output logic                   cmdDone,
  output logic                   rdValid,
  output logic [7:0]             rdData,
  // Link
  dfr_link_if.host               link
);

  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} dfr_hstate_t;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic       soS1_r, soS2_r;
  logic [7:0] bbS1_r, bbS2_r;

  always_ff @(posedge ref_clk) begin
    soS1_r <= link.soLine;
    soS2_r <= soS1_r;
    bbS1_r <= link.byteBus;
    bbS2_r <= bbS1_r;
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  dfr_hstate_t st_r,    st_nxt;
  logic [2:0]  div_r,   div_nxt;
  logic [15:0] clk_r,   clk_nxt;
  logic [15:0] tot_r,   tot_nxt;
  logic [15:0] dst_r,   dst_nxt;
  logic [39:0] tx_r,    tx_nxt;
  logic        bm_r,    bm_nxt;
  logic        sck_r,   sck_nxt;
  logic        csN_r,   csN_nxt;
  logic        si_r,    si_nxt;
  logic [7:0]  hbo_r,   hbo_nxt;
  logic        hbe_r,   hbe_nxt;
  logic [7:0]  rxSh_r,  rxSh_nxt;
  logic [2:0]  rxCnt_r, rxCnt_nxt;
  logic        rv_r,    rv_nxt;
  logic [7:0]  rd_r,    rd_nxt;
  logic        done_r,  done_nxt;
  logic        busy_r,  busy_nxt;

  dfr_kind_t   kind;
  logic [31:0] adrWord;
  logic [39:0] txShift;
  logic        halfDone;

  always_comb begin
    kind     = decodeKind(cmdOpcode, cmdByteMode);
    adrWord  = isBufKind(kind) ? {21'h000000, cmdAddr[OFF_W-1:0]}
                               : {7'h00, cmdAddr};
    txShift  = bm_r ? {tx_r[31:0], 8'h00} : {tx_r[38:0], 1'b0};
    halfDone = (div_r == HALF_DIV - 3'h1);
    st_nxt    = st_r;
    div_nxt   = halfDone ? 3'h0 : div_r + 3'h1;
    clk_nxt   = clk_r;
    tot_nxt   = tot_r;
    dst_nxt   = dst_r;
    tx_nxt    = tx_r;
    bm_nxt    = bm_r;
    sck_nxt   = sck_r;
    csN_nxt   = csN_r;
    si_nxt    = si_r;
    hbo_nxt   = hbo_r;
    hbe_nxt   = hbe_r;
    rxSh_nxt  = rxSh_r;
    rxCnt_nxt = rxCnt_r;
    rv_nxt    = 1'b0;
    rd_nxt    = rd_r;
    done_nxt  = 1'b0;
    busy_nxt  = busy_r;
    unique case (st_r)
      H_IDLE: begin
        div_nxt = 3'h0;
        if (cmdStart) begin
          st_nxt    = H_LOW;
          bm_nxt    = cmdByteMode;
          csN_nxt   = 1'b0;
          busy_nxt  = 1'b1;
          clk_nxt   = 16'h0000;
          tx_nxt    = {cmdOpcode, adrWord};
          si_nxt    = cmdOpcode[7];
          hbo_nxt   = cmdOpcode;
          hbe_nxt   = cmdByteMode;
          rxCnt_nxt = 3'h0;
          dst_nxt   = 16'({10'h000, (cmdByteMode ? BYTE_OPC_CLKS + BYTE_ADR_CLKS
                                                 : SER_OPC_CLKS + SER_ADR_CLKS)}
                          + {10'h000, dummyClks(kind, cmdByteMode)});
          tot_nxt   = 16'({10'h000, (cmdByteMode ? BYTE_OPC_CLKS + BYTE_ADR_CLKS
                                                 : SER_OPC_CLKS + SER_ADR_CLKS)}
                          + {10'h000, dummyClks(kind, cmdByteMode)}
                          + (cmdByteMode ? {4'h0, cmdLen} : {1'b0, cmdLen, 3'b000}));
        end
      end
      H_LOW: begin
        if (halfDone) begin
          st_nxt  = H_HIGH;
          sck_nxt = 1'b1;
          if (clk_r >= dst_r) begin
            if (bm_r) begin
              rv_nxt = 1'b1;
              rd_nxt = bbS2_r;
            end else begin
              rxSh_nxt  = {rxSh_r[6:0], soS2_r};
              rxCnt_nxt = rxCnt_r + 3'h1;
              if (rxCnt_r == 3'h7) begin
                rv_nxt = 1'b1;
                rd_nxt = {rxSh_r[6:0], soS2_r};
              end
            end
          end
        end
      end
      H_HIGH: begin
        if (halfDone) begin
          sck_nxt = 1'b0;
          if (clk_r == tot_r - 16'h0001) begin
            st_nxt  = H_END;
            hbe_nxt = 1'b0;
          end else begin
            st_nxt  = H_LOW;
            clk_nxt = clk_r + 16'h0001;
            tx_nxt  = txShift;
            si_nxt  = txShift[39];
            hbo_nxt = txShift[39:32];
            // Stop driving on the falling link edge where the device turns the bus round
            hbe_nxt = bm_r && (clk_r + 16'h0001 < dst_r);
          end
        end
      end
      H_END: begin
        if (halfDone) begin
          st_nxt   = H_IDLE;
          csN_nxt  = 1'b1;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
    endcase
    if (rst) begin
      st_nxt    = H_IDLE;
      div_nxt   = 3'h0;
      clk_nxt   = 16'h0000;
      tot_nxt   = 16'h0000;
      dst_nxt   = 16'h0000;
      tx_nxt    = '0;
      bm_nxt    = 1'b0;
      sck_nxt   = 1'b0;
      csN_nxt   = 1'b1;
      si_nxt    = 1'b0;
      hbo_nxt   = 8'h00;
      hbe_nxt   = 1'b0;
      rxSh_nxt  = 8'h00;
      rxCnt_nxt = 3'h0;
      rv_nxt    = 1'b0;
      rd_nxt    = 8'h00;
      done_nxt  = 1'b0;
      busy_nxt  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_r    <= st_nxt;
    div_r   <= div_nxt;
    clk_r   <= clk_nxt;
    tot_r   <= tot_nxt;
    dst_r   <= dst_nxt;
    tx_r    <= tx_nxt;
    bm_r    <= bm_nxt;
    sck_r   <= sck_nxt;
    csN_r   <= csN_nxt;
    si_r    <= si_nxt;
    hbo_r   <= hbo_nxt;
    hbe_r   <= hbe_nxt;
    rxSh_r  <= rxSh_nxt;
    rxCnt_r <= rxCnt_nxt;
    rv_r    <= rv_nxt;
    rd_r    <= rd_nxt;
    done_r  <= done_nxt;
    busy_r  <= busy_nxt;
  end

  assign link.csN             = csN_r;
  assign link.sck             = sck_r;
  assign link.si              = si_r;
  assign link.hostByteOut     = hbo_r;
  assign link.hostByteOe      = hbe_r;
  assign link.linkWidthSelect = bm_r;
  assign cmdBusy              = busy_r;
  assign cmdDone              = done_r;
  assign rdValid              = rv_r;
  assign rdData               = rd_r;

endmodule

// ### tb/dfr_link_props.sv
/*
  Concurrent checks on the command link between host and device ends.
  Assumes sck is a ref_clk flop, so sampling on ref_clk sees every link edge.
*/
module dfr_link_props (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Link
  input wire logic       csN,
  input wire logic       sck,
  input wire logic       si,
  input wire logic       soLine,
  input wire logic       soOe,
  input wire logic       linkWidthSelect,
  input wire logic       hostByteOe,
  input wire logic       devByteOe,
  input wire logic [7:0] byteBus
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Link clock rises seen in the current frame
  // ---------------------------------------------------------------
  logic [15:0] clkCnt_r;
  logic [15:0] clkCnt_nxt;
  logic        sckPrev_r;

  // Frame end clears the count, so no reset is needed here
  always_comb begin
    clkCnt_nxt = clkCnt_r;
    if (csN) clkCnt_nxt = 16'h0000;
    else if (sck && !sckPrev_r) clkCnt_nxt = clkCnt_r + 16'h0001;
  end

  always_ff @(posedge ref_clk) begin
    clkCnt_r  <= clkCnt_nxt;
    sckPrev_r <= sck;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  outputs_float_a: assert property (csN |-> !soOe && !devByteOe)
    else $error("device drives the link while deselected");
  sck_idle_a: assert property (csN |-> !sck)
    else $error("link clock not low outside a frame");
  width_static_a: assert property (!csN && !$past(csN) |-> $stable(linkWidthSelect))
    else $error("width select changed inside a frame");
  serial_stable_a: assert property (!csN && sck |-> $stable(soLine) && $stable(si))
    else $error("serial line moved while link clock high");
  byte_stable_a: assert property (!csN && sck |-> $stable(byteBus))
    else $error("byte bus moved while link clock high");
  serial_owner_a: assert property (soOe |-> !linkWidthSelect && !devByteOe)
    else $error("serial output driven on byte link");
  byte_owner_a: assert property (devByteOe |-> linkWidthSelect && !hostByteOe)
    else $error("byte bus owner conflict");
  oe_hold_a: assert property (!csN && (soOe || devByteOe) |=> csN || soOe || devByteOe)
    else $error("device output dropped inside a frame");
  serial_lead_a: assert property ($rose(soOe) |-> clkCnt_r == 16'h0030 || clkCnt_r == 16'h0040)
    else $error("serial data began after a wrong clock count");
  byte_lead_a: assert property ($rose(devByteOe) |-> clkCnt_r == 16'h0007 || clkCnt_r == 16'h0018)
    else $error("byte data began after a wrong clock count");
endmodule

// ### tb/tb_top.sv
/*
  Testbench joining host and device ends over one link, with an array model.
  Assumes buffers are filled through the fill port before any buffer read.
*/
module tb_top
  import dfr_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [7:0]  opc;
    logic        bm;
    logic [13:0] pg;
    logic [10:0] off;
    logic [7:0]  len;
  } dfr_row_t;

  logic              ref_clk     = 1'b0;
  logic              rst         = 1'b1;
  logic              cmdStart    = 1'b0;
  logic [7:0]        cmdOpcode   = 8'h00;
  logic [ADDR_W-1:0] cmdAddr     = '0;
  logic              cmdByteMode = 1'b0;
  logic [11:0]       cmdLen      = 12'h000;
  logic              cmdBusy;
  logic              cmdDone;
  logic              rdValid;
  logic [7:0]        rdData;
  logic [ADDR_W-1:0] arrayAddr;
  logic [7:0]        arrayData;
  logic              bufWrEn     = 1'b0;
  logic              bufWrSel    = 1'b0;
  logic [OFF_W-1:0]  bufWrAddr   = '0;
  logic [7:0]        bufWrData   = 8'h00;
  int                failures    = 0;
  int                total_checks = 0;
  int                cycles      = 0;

  // Page bits mixed in so a wrong page shows up as wrong data
  function automatic logic [7:0] arrByte(logic [13:0] pg, logic [10:0] of);
    return of[7:0] ^ {pg[6:0], 1'b1};
  endfunction

  function automatic logic [7:0] bufByte(logic s, logic [10:0] a);
    return a[7:0] ^ (s ? 8'hA5 : 8'h3C);
  endfunction

  function automatic logic [7:0] expByte(dfr_row_t r, int n);
    logic [13:0] pg;
    logic [10:0] of;
    logic        isArr;
    logic        isBuf;
    pg = r.pg;
    of = r.off;
    isArr = (r.opc == OPC_CONT) || (r.opc == OPC_PAGE);
    isBuf = r.bm ? (r.opc == OPC_BBUF1 || r.opc == OPC_BBUF2) : (r.opc == OPC_SBUF1 || r.opc == OPC_SBUF2);
    for (int i = 0; i < n; i++) begin
      if (of == LAST_OFF) begin
        of = 11'h000;
        if (r.opc == OPC_CONT) pg = pg + PAGE_ONE;
      end else of = of + 11'h001;
    end
    if (isArr) return arrByte(pg, of);
    if (isBuf) return bufByte(r.opc == OPC_SBUF2 || r.opc == OPC_BBUF2, of);
    return 8'hFF;
  endfunction

  localparam dfr_row_t ROWS [8] = '{
    '{OPC_CONT,  1'b0, 14'h0005, 11'h41E, 8'h03},
    '{OPC_CONT,  1'b1, 14'h3FFF, 11'h41F, 8'h02},
    '{OPC_PAGE,  1'b0, 14'h0007, 11'h41F, 8'h02},
    '{OPC_PAGE,  1'b1, 14'h0007, 11'h41E, 8'h03},
    '{OPC_SBUF1, 1'b0, 14'h0000, 11'h41F, 8'h02},
    '{OPC_SBUF2, 1'b0, 14'h0000, 11'h003, 8'h02},
    '{OPC_BBUF1, 1'b1, 14'h0000, 11'h41F, 8'h02},
    '{OPC_BBUF2, 1'b1, 14'h0000, 11'h000, 8'h02}
  };

  always #12.5 ref_clk = ~ref_clk;

  assign arrayData = arrByte(arrayAddr[24:11], arrayAddr[10:0]);

  dfr_link_if link();

  dfr_host dfr_host_inst (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .cmdStart    (cmdStart),
    .cmdOpcode   (cmdOpcode),
    .cmdAddr     (cmdAddr),
    .cmdByteMode (cmdByteMode),
    .cmdLen      (cmdLen),
    .cmdBusy     (cmdBusy),
    .cmdDone     (cmdDone),
    .rdValid     (rdValid),
    .rdData      (rdData),
    .link        (link)
  );

  dfr_dev dfr_dev_inst (
    .link      (link),
    .rst       (rst),
    .arrayAddr (arrayAddr),
    .arrayData (arrayData),
    .usrClk    (ref_clk),
    .bufWrEn   (bufWrEn),
    .bufWrSel  (bufWrSel),
    .bufWrAddr (bufWrAddr),
    .bufWrData (bufWrData)
  );

  dfr_link_props dfr_link_props_inst (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .csN             (link.csN),
    .sck             (link.sck),
    .si              (link.si),
    .soLine          (link.soLine),
    .soOe            (link.soOe),
    .linkWidthSelect (link.linkWidthSelect),
    .hostByteOe      (link.hostByteOe),
    .devByteOe       (link.devByteOe),
    .byteBus         (link.byteBus)
  );

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("Checks made %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic runCmd(dfr_row_t r);
    int n;
    n = 0;
    @(negedge ref_clk);
    cmdOpcode   = r.opc;
    cmdAddr     = {r.pg, r.off};
    cmdByteMode = r.bm;
    cmdLen      = {4'h0, r.len};
    cmdStart    = 1'b1;
    @(negedge ref_clk);
    cmdStart = 1'b0;
    check("cmdBusy start", 8'h01, {7'h00, cmdBusy});
    for (int g = 0; g < 4000 && cmdDone !== 1'b1; g++) begin
      @(posedge ref_clk);
      #1;
      if (rdValid === 1'b1) begin
        check("rdData", expByte(r, n), rdData);
        n++;
      end
    end
    check("byte count", r.len, n[7:0]);
    // A command that never finishes counts as a mismatch here
    check("cmdDone", 8'h01, {7'h00, cmdDone});
    check("cmdBusy end", 8'h00, {7'h00, cmdBusy});
  endtask

  // Hang guard, well above the expected run of about 8000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    check("csN idle", 8'h01, {7'h00, link.csN});
    check("oe idle", 8'h00, {6'h00, link.soOe, link.devByteOe});
    for (int s = 0; s < 2; s++) begin
      for (int a = 0; a < PAGE_BYTES; a++) begin
        @(negedge ref_clk);
        bufWrEn   = 1'b1;
        bufWrSel  = s[0];
        bufWrAddr = a[10:0];
        bufWrData = bufByte(s[0], a[10:0]);
      end
    end
    @(negedge ref_clk);
    bufWrEn = 1'b0;
    foreach (ROWS[i]) runCmd(ROWS[i]);
    // Serial buffer opcode on the byte link must stay silent
    runCmd(dfr_row_t'{OPC_SBUF1, 1'b1, 14'h0000, 11'h005, 8'h02});
    runCmd(dfr_row_t'{OPC_BBUF2, 1'b0, 14'h0000, 11'h005, 8'h02});
    runCmd(dfr_row_t'{OPC_CONT, 1'b0, 14'h3FFF, 11'h41F, 8'h02});
    runCmd(dfr_row_t'{OPC_SBUF2, 1'b0, 14'h0000, 11'h41F, 8'h02});
    // Reset in mid-frame must drop select and free the link
    @(negedge ref_clk);
    cmdOpcode   = OPC_CONT;
    cmdByteMode = 1'b0;
    cmdLen      = 12'h004;
    cmdStart    = 1'b1;
    @(negedge ref_clk);
    cmdStart = 1'b0;
    repeat (300) @(negedge ref_clk);
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    check("csN after reset", 8'h01, {7'h00, link.csN});
    check("oe after reset", 8'h00, {6'h00, link.soOe, link.devByteOe});
    check("busy after reset", 8'h00, {7'h00, cmdBusy});
    runCmd(ROWS[0]);
    end_of_test();
  end
endmodule
